// File: logic/crss_pkg.sv
// Constants, register map and state encoding for the core regulator start-up sequencer.
// Assumes a 125 MHz aclk and a one-cycle pwm_cycle pulse per PWM period.
`default_nettype none
package crss_pkg;
	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 8;
	localparam int START_DELAY_US = 100;
	localparam int START_DELAY_CYCLES = (START_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PG_DELAY_US = 6800;
	localparam int PG_DELAY_MIN_US = 5500;
	localparam int PG_DELAY_MAX_US = 8100;
	localparam int PG_DELAY_CYCLES = PG_DELAY_US * 1000 / CLK_PERIOD_NS;
	localparam int QUAL_PWM_CYCLES = 6;
	// Reference is kept in half-millivolt steps so the 12.5 mV code step is exact
	localparam int REF_LSB_UV = 500;
	localparam int FAST_SLEW_MV_PER_US = 10;
	localparam int FAST_CURRENT_UA = 200;
	localparam int SLOW_CURRENT_UA = 41;
	localparam int FAST_STEP_NS = REF_LSB_UV / FAST_SLEW_MV_PER_US;
	localparam int SLOW_STEP_NS = FAST_STEP_NS * FAST_CURRENT_UA / SLOW_CURRENT_UA;
	localparam int FAST_STEP_CYCLES = (FAST_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SLOW_STEP_CYCLES = (SLOW_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// ----------------------------------------------------------------
	// Reference levels and widths
	// ----------------------------------------------------------------
	localparam int REF_W = 12;
	localparam int TIMER_W = 20;
	localparam int QUAL_W = 3;
	localparam int STEP_W = 6;
	localparam int VCODE_W = 7;
	localparam logic [11:0] BOOT_REF = 12'h960;
	localparam logic [11:0] VCODE_ZERO_REF = 12'hBB8;
	localparam logic [11:0] VCODE_STEP_REF = 12'h019;
	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [3:0] CTRL_OFFSET = 4'h0;
	localparam logic [3:0] STATUS_OFFSET = 4'h4;
	localparam logic [3:0] TARGET_OFFSET = 4'h8;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
	localparam int CTRL_ALERT_EN_BIT = 0;
	localparam int ST_STATE_LSB = 0;
	localparam int ST_LATCHED_BIT = 3;
	localparam int ST_CLKEN_BIT = 4;
	localparam int ST_POWER_OK_OUTPUT_BIT = 5;
	localparam int ST_DEM_BIT = 6;
	localparam int ST_FAST_BIT = 7;
	localparam int ST_SLEEP_BIT = 8;
	localparam int ST_WIDE_BIT = 9;
	localparam int ST_REF_LSB = 16;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ----------------------------------------------------------------
	// Sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		CRSS_IDLE = 3'h0,
		CRSS_DELAY = 3'h1,
		CRSS_SOFT = 3'h2,
		CRSS_SLEW = 3'h3,
		CRSS_RUN = 3'h4,
		CRSS_LATCHED = 3'h5
	} crss_state_type;
endpackage : crss_pkg
`default_nettype wire

// File: logic/crss_axil.sv
// AXI4-Lite register slave for the sequencer: one control word, two read-only words.
// Assumes a master that keeps at most one write and one read outstanding.
`default_nettype none
module crss_axil #(
	parameter int ADDR_W = 4
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] status_word,
	input wire logic [31:0] target_word,
	output logic alert_enable
);
	logic aw_hold_r;
	logic w_hold_r;
	logic [ADDR_W-1:0] awaddr_r;
	logic [31:0] wdata_r;
	logic wstrb0_r;
	logic [31:0] ctrl_r;

	function automatic logic crss_hit(input logic [ADDR_W-1:0] addr, input logic [3:0] offset);
		crss_hit = (addr[ADDR_W-1:2] == offset[ADDR_W-1:2]);
	endfunction : crss_hit

	// ----------------------------------------------------------------
	// Write channels, taken in either order
	// ----------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			awaddr_r <= '0;
			wdata_r <= 32'h0000_0000;
			wstrb0_r <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= crss_pkg::RESP_OKAY;
			ctrl_r <= crss_pkg::CTRL_RESET;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_hold_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_hold_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb0_r <= s_axi_wstrb[0];
				s_axi_wready <= 1'b0;
			end
			if (aw_hold_r && w_hold_r && !s_axi_bvalid)
			begin
				aw_hold_r <= 1'b0;
				w_hold_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (crss_hit(awaddr_r, crss_pkg::CTRL_OFFSET))
				begin
					s_axi_bresp <= crss_pkg::RESP_OKAY;
					if (wstrb0_r)
						ctrl_r[crss_pkg::CTRL_ALERT_EN_BIT] <= wdata_r[crss_pkg::CTRL_ALERT_EN_BIT];
				end
				else if (crss_hit(awaddr_r, crss_pkg::STATUS_OFFSET) || crss_hit(awaddr_r, crss_pkg::TARGET_OFFSET))
					s_axi_bresp <= crss_pkg::RESP_OKAY;
				else
					s_axi_bresp <= crss_pkg::RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Read channel
	// ----------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= crss_pkg::RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= crss_pkg::RESP_OKAY;
			if (crss_hit(s_axi_araddr, crss_pkg::CTRL_OFFSET))
				s_axi_rdata <= ctrl_r;
			else if (crss_hit(s_axi_araddr, crss_pkg::STATUS_OFFSET))
				s_axi_rdata <= status_word;
			else if (crss_hit(s_axi_araddr, crss_pkg::TARGET_OFFSET))
				s_axi_rdata <= target_word;
			else
			begin
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= crss_pkg::RESP_SLVERR;
			end
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	assign alert_enable = ctrl_r[crss_pkg::CTRL_ALERT_EN_BIT];
endmodule : crss_axil
`default_nettype wire

// File: logic/crss_sequencer.sv
// Start-up sequencer and mode control of a single-phase core regulator, with AXI4-Lite status.
// Assumes all pins synchronous to aclk, pwm_cycle one pulse per PWM period, and an analog
// comparator that reports whether the output is within the boot window.
//
// The register addresses and register access over AXI4-Lite are this design's own decisions.
`default_nettype none
module crss_sequencer #(
	parameter int ADDR_W = 4,
	parameter int START_DELAY_CYCLES = crss_pkg::START_DELAY_CYCLES,
	parameter int PG_DELAY_CYCLES = crss_pkg::PG_DELAY_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic supply_ok,
	input wire logic regulator_enable,
	input wire logic platform_power_ok_input,
	input wire logic pwm_cycle,
	input wire logic output_in_boot_window,
	input wire logic forced_emulation_enable,
	input wire logic deeper_sleep_enable,
	input wire logic deep_sleep_wake_n,
	input wire logic [crss_pkg::VCODE_W-1:0] voltage_code,
	input wire logic over_temperature,
	output logic clock_enable_n,
	output logic converter_on,
	output logic [crss_pkg::REF_W-1:0] soft_ref_level,
	output logic ramp_current_fast,
	output logic diode_emulation,
	output logic wide_hysteresis,
	output logic deeper_sleep_mode,
	output logic power_ok_output_o,
	output logic power_ok_output_oe_n,
	output logic thermal_alert_n_o,
	output logic thermal_alert_n_oe_n
);
	crss_pkg::crss_state_type state_r;
	crss_pkg::crss_state_type state_nxt;
	logic [crss_pkg::TIMER_W-1:0] timer_r;
	logic [crss_pkg::QUAL_W-1:0] qual_cnt_r;
	logic [crss_pkg::STEP_W-1:0] step_cnt_r;
	logic [crss_pkg::REF_W-1:0] soft_ref_r;
	logic [crss_pkg::REF_W-1:0] target_ref;
	logic [crss_pkg::REF_W-1:0] code_ref;
	logic [crss_pkg::STEP_W-1:0] step_len;
	logic pgd_prev_r;
	logic clock_enable_n_r;
	logic converter_on_r;
	logic ramp_fast_r;
	logic dem_r;
	logic wide_r;
	logic sleep_r;
	logic pg_oe_n_r;
	logic tt_oe_n_r;
	logic pin_low_r;
	logic enable_ok;
	logic qualified;
	logic alert_enable;
	logic [31:0] status_word;

	// ----------------------------------------------------------------
	// Voltage code to reference
	// ----------------------------------------------------------------
	// Codes above 0x78 would go negative; they clamp to zero instead of wrapping
	function automatic logic [11:0] crss_code_ref(input logic [6:0] code);
		logic [11:0] drop;
		drop = 12'({5'h00, code} * crss_pkg::VCODE_STEP_REF);
		if (drop > crss_pkg::VCODE_ZERO_REF)
			crss_code_ref = 12'h000;
		else
			crss_code_ref = crss_pkg::VCODE_ZERO_REF - drop;
	endfunction : crss_code_ref

	function automatic logic crss_powered(input crss_pkg::crss_state_type s);
		crss_powered = (s == crss_pkg::CRSS_SLEW) || (s == crss_pkg::CRSS_RUN);
	endfunction : crss_powered

	assign code_ref = crss_code_ref(voltage_code);
	assign enable_ok = regulator_enable && supply_ok;
	assign qualified = output_in_boot_window && (qual_cnt_r >= crss_pkg::QUAL_W'(crss_pkg::QUAL_PWM_CYCLES));

	// ----------------------------------------------------------------
	// Sequence state
	// ----------------------------------------------------------------
	always_comb
	begin
		state_nxt = state_r;
		if (!enable_ok)
			state_nxt = crss_pkg::CRSS_IDLE;
		else
		begin
			case (state_r)
				crss_pkg::CRSS_IDLE: state_nxt = crss_pkg::CRSS_DELAY;
				crss_pkg::CRSS_DELAY:
				begin
					if (timer_r == crss_pkg::TIMER_W'(START_DELAY_CYCLES - 1))
						state_nxt = crss_pkg::CRSS_SOFT;
				end
				crss_pkg::CRSS_SOFT:
				begin
					// Only a falling power-ok latches here: it may still be low from before start
					if (pgd_prev_r && !platform_power_ok_input)
						state_nxt = crss_pkg::CRSS_LATCHED;
					else if (qualified)
						state_nxt = crss_pkg::CRSS_SLEW;
				end
				crss_pkg::CRSS_SLEW:
				begin
					if (!platform_power_ok_input)
						state_nxt = crss_pkg::CRSS_LATCHED;
					else if (timer_r == crss_pkg::TIMER_W'(PG_DELAY_CYCLES - 1))
						state_nxt = crss_pkg::CRSS_RUN;
				end
				crss_pkg::CRSS_RUN:
				begin
					if (!platform_power_ok_input)
						state_nxt = crss_pkg::CRSS_LATCHED;
				end
				crss_pkg::CRSS_LATCHED: state_nxt = crss_pkg::CRSS_LATCHED;
				default: state_nxt = crss_pkg::CRSS_IDLE;
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			state_r <= crss_pkg::CRSS_IDLE;
		else
			state_r <= state_nxt;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			timer_r <= '0;
		else if (state_nxt != state_r)
			timer_r <= '0;
		else if (state_r == crss_pkg::CRSS_DELAY || state_r == crss_pkg::CRSS_SLEW)
			timer_r <= timer_r + 1'b1;
	end

	// ----------------------------------------------------------------
	// Power-ok qualification
	// ----------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			qual_cnt_r <= '0;
			pgd_prev_r <= 1'b0;
		end
		else
		begin
			pgd_prev_r <= platform_power_ok_input;
			if (state_r != crss_pkg::CRSS_SOFT || !platform_power_ok_input)
				qual_cnt_r <= '0;
			else if (pwm_cycle && !qualified && qual_cnt_r < crss_pkg::QUAL_W'(crss_pkg::QUAL_PWM_CYCLES))
				qual_cnt_r <= qual_cnt_r + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Soft-start reference ramp
	// ----------------------------------------------------------------
	always_comb
	begin
		case (state_r)
			crss_pkg::CRSS_SOFT: target_ref = crss_pkg::BOOT_REF;
			crss_pkg::CRSS_SLEW: target_ref = code_ref;
			crss_pkg::CRSS_RUN: target_ref = code_ref;
			default: target_ref = 12'h000;
		endcase
		if (ramp_fast_r)
			step_len = crss_pkg::STEP_W'(crss_pkg::FAST_STEP_CYCLES);
		else
			step_len = crss_pkg::STEP_W'(crss_pkg::SLOW_STEP_CYCLES);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			soft_ref_r <= '0;
			step_cnt_r <= '0;
		end
		else if (!converter_on_r)
		begin
			soft_ref_r <= '0;
			step_cnt_r <= '0;
		end
		else if (step_cnt_r >= step_len - 1'b1)
		begin
			step_cnt_r <= '0;
			if (soft_ref_r < target_ref)
				soft_ref_r <= soft_ref_r + 1'b1;
			else if (soft_ref_r > target_ref)
				soft_ref_r <= soft_ref_r - 1'b1;
		end
		else
			step_cnt_r <= step_cnt_r + 1'b1;
	end

	// ----------------------------------------------------------------
	// Outputs and operating modes
	// ----------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			clock_enable_n_r <= 1'b1;
			converter_on_r <= 1'b0;
			pg_oe_n_r <= 1'b0;
			ramp_fast_r <= 1'b0;
			pin_low_r <= 1'b0;
		end
		else
		begin
			clock_enable_n_r <= !crss_powered(state_nxt);
			converter_on_r <= (state_nxt == crss_pkg::CRSS_SOFT) || crss_powered(state_nxt);
			pg_oe_n_r <= (state_nxt == crss_pkg::CRSS_RUN);
			ramp_fast_r <= (state_nxt == crss_pkg::CRSS_SLEW)
				|| (state_nxt == crss_pkg::CRSS_RUN && !deeper_sleep_enable);
			pin_low_r <= 1'b0;
		end
	end

	// Conduction mode only follows the sleep pins once power-good is up
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			dem_r <= 1'b0;
			wide_r <= 1'b0;
			sleep_r <= 1'b0;
		end
		else
		begin
			sleep_r <= deeper_sleep_enable || !deep_sleep_wake_n;
			dem_r <= (state_nxt == crss_pkg::CRSS_RUN)
				&& (deeper_sleep_enable || (forced_emulation_enable && !deep_sleep_wake_n));
			wide_r <= (state_nxt == crss_pkg::CRSS_RUN) && forced_emulation_enable && !deep_sleep_wake_n;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			tt_oe_n_r <= 1'b1;
		else
			tt_oe_n_r <= !(over_temperature && alert_enable);
	end

	assign clock_enable_n = clock_enable_n_r;
	assign converter_on = converter_on_r;
	assign soft_ref_level = soft_ref_r;
	assign ramp_current_fast = ramp_fast_r;
	assign diode_emulation = dem_r;
	assign wide_hysteresis = wide_r;
	assign deeper_sleep_mode = sleep_r;
	assign power_ok_output_o = pin_low_r;
	assign power_ok_output_oe_n = pg_oe_n_r;
	assign thermal_alert_n_o = pin_low_r;
	assign thermal_alert_n_oe_n = tt_oe_n_r;

	// ----------------------------------------------------------------
	// Register slave
	// ----------------------------------------------------------------
	always_comb
	begin
		status_word = 32'h0000_0000;
		status_word[crss_pkg::ST_STATE_LSB +: 3] = state_r;
		status_word[crss_pkg::ST_LATCHED_BIT] = (state_r == crss_pkg::CRSS_LATCHED);
		status_word[crss_pkg::ST_CLKEN_BIT] = !clock_enable_n_r;
		status_word[crss_pkg::ST_POWER_OK_OUTPUT_BIT] = pg_oe_n_r;
		status_word[crss_pkg::ST_DEM_BIT] = dem_r;
		status_word[crss_pkg::ST_FAST_BIT] = ramp_fast_r;
		status_word[crss_pkg::ST_SLEEP_BIT] = sleep_r;
		status_word[crss_pkg::ST_WIDE_BIT] = wide_r;
		status_word[crss_pkg::ST_REF_LSB +: crss_pkg::REF_W] = soft_ref_r;
	end

	crss_axil #(
		.ADDR_W(ADDR_W)
	) u_regs (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.status_word(status_word),
		.target_word({20'h00000, code_ref}),
		.alert_enable(alert_enable)
	);

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_idle_no_enable;
		state_r == crss_pkg::CRSS_IDLE && !enable_ok;
	endsequence

	sequence s_pg_released;
		$rose(pg_oe_n_r);
	endsequence

	a_no_early_start: assert property (s_idle_no_enable |=> state_r == crss_pkg::CRSS_IDLE)
		else $error("sequence left idle without enable");
	a_start_delay: assert property ($past(state_r) == crss_pkg::CRSS_DELAY && state_r == crss_pkg::CRSS_SOFT
		|-> $past(timer_r) == crss_pkg::TIMER_W'(START_DELAY_CYCLES - 1))
		else $error("boot ramp began at the wrong time");
	a_ccm_startup: assert property ($past(state_nxt) != crss_pkg::CRSS_RUN |-> !dem_r && !wide_r)
		else $error("diode emulation before power-good");
	a_boot_slow: assert property (state_r == crss_pkg::CRSS_SOFT |-> !ramp_fast_r)
		else $error("fast ramp during boot");
	a_clk_qualify: assert property ($fell(clock_enable_n_r) |-> $past(output_in_boot_window)
		&& $past(qual_cnt_r) >= crss_pkg::QUAL_W'(crss_pkg::QUAL_PWM_CYCLES))
		else $error("clock enable without qualified power-ok");
	a_fast_slew: assert property ($fell(clock_enable_n_r) |-> ramp_fast_r)
		else $error("fast ramp not selected after clock enable");
	a_pg_delay: assert property (s_pg_released |-> $past(timer_r) == crss_pkg::TIMER_W'(PG_DELAY_CYCLES - 1)
		&& !$past(clock_enable_n_r))
		else $error("power-good delay wrong");
	a_latch_off: assert property (crss_powered(state_r) && !platform_power_ok_input && enable_ok
		|=> state_r == crss_pkg::CRSS_LATCHED ##1 !converter_on_r)
		else $error("no latch-off on power-ok loss");
	a_latch_hold: assert property (state_r == crss_pkg::CRSS_LATCHED && enable_ok
		|=> state_r == crss_pkg::CRSS_LATCHED)
		else $error("latch-off cleared without enable toggle");
	a_dem_window: assert property (state_nxt == crss_pkg::CRSS_RUN && forced_emulation_enable
		&& !deep_sleep_wake_n |=> dem_r && wide_r)
		else $error("forced emulation not applied");
	a_sleep_flag: assert property (deeper_sleep_enable || !deep_sleep_wake_n |=> sleep_r)
		else $error("deeper sleep not flagged");
	a_thermal_pin: assert property (over_temperature && alert_enable |=> !tt_oe_n_r && !thermal_alert_n_o)
		else $error("thermal alert not pulled low");
	a_disable_state: assert property (!enable_ok |=> clock_enable_n_r && !pg_oe_n_r
		&& state_r == crss_pkg::CRSS_IDLE)
		else $error("outputs not idle while disabled");
endmodule : crss_sequencer
`default_nettype wire

// File: tb/crss_far_end.sv
// Far side model: chipset power-ok, PWM period pulse and output-window comparator.
// Assumes the bench sets the wanted levels; all outputs change just after a rising edge.
`default_nettype none
module crss_far_end #(
	parameter int PWM_DIV = 10
) (
	input wire logic aclk,
	input wire logic pok_req,
	input wire logic win_req,
	output logic pwm_cycle,
	output logic platform_power_ok_input,
	output logic output_in_boot_window
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------------------------------
	// Chipset and comparator
	// ----------------------------------------------------------------
	int cnt = 0;
	initial
	begin
		pwm_cycle = 1'h0;
		platform_power_ok_input = 1'h0;
		output_in_boot_window = 1'h0;
	end
	always @(posedge aclk)
	begin
		cnt <= (cnt == PWM_DIV - 1) ? 0 : cnt + 1;
		pwm_cycle <= (cnt == PWM_DIV - 1);
		platform_power_ok_input <= pok_req;
		output_in_boot_window <= win_req;
	end
endmodule : crss_far_end
`default_nettype wire

// File: tb/test_crss_sequencer.sv
// Self-checking bench for the core regulator start-up sequencer.
// Assumes short delay parameters; the far side comes from crss_far_end.
`default_nettype none
`define CHK(e, a) note(32'(e), 32'(a))
module test_crss_sequencer;
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------------------------------
	// Signals and instances
	// ----------------------------------------------------------------
	localparam int PG = 50;
	localparam int SD = 20;
	logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, supply_ok = 1'h0, regulator_enable = 1'h0;
	logic forced_emulation_enable = 1'h0, deeper_sleep_enable = 1'h0, deep_sleep_wake_n = 1'h1;
	logic over_temperature = 1'h0, pok_req = 1'h0, win_req = 1'h0;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, obs;
	logic [6:0] voltage_code = 7'h00;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [11:0] soft_ref_level;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pwm_cycle;
	logic platform_power_ok_input, output_in_boot_window, clock_enable_n, converter_on, ramp_current_fast;
	logic diode_emulation, wide_hysteresis, deeper_sleep_mode, power_ok_output_o, power_ok_output_oe_n;
	logic thermal_alert_n_o, thermal_alert_n_oe_n;
	logic [31:0] q[$];
	event got;
	int num_checks = 0, fail_count = 0, seed = 87314, cyc = 0, n;
	crss_sequencer #(.START_DELAY_CYCLES(SD), .PG_DELAY_CYCLES(PG)) dut_u (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .supply_ok, .regulator_enable, .platform_power_ok_input, .pwm_cycle,
		.output_in_boot_window, .forced_emulation_enable, .deeper_sleep_enable, .deep_sleep_wake_n,
		.voltage_code, .over_temperature, .clock_enable_n, .converter_on, .soft_ref_level, .ramp_current_fast,
		.diode_emulation, .wide_hysteresis, .deeper_sleep_mode, .power_ok_output_o, .power_ok_output_oe_n,
		.thermal_alert_n_o, .thermal_alert_n_oe_n);
	crss_far_end far_u (.aclk, .pok_req, .win_req, .pwm_cycle, .platform_power_ok_input, .output_in_boot_window);
	initial forever #4 aclk = ~aclk;
	// ----------------------------------------------------------------
	// Checking and bus tasks
	// ----------------------------------------------------------------
	// Whole run is a few hundred cycles, so this ceiling only trips on a hang
	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			fail_count++;
			results();
		end
	end
	always @(got)
	begin
		num_checks++;
		if (q[0] !== obs)
		begin
			fail_count++;
			$display("CHECK FAILED t=%0t exp=%h got=%h", $time, q[0], obs);
		end
		void'(q.pop_front());
	end
	task automatic note(input logic [31:0] e, input logic [31:0] a);
		q.push_back(e);
		obs = a;
		->got;
		// Zero delay lets the checker run while every check still sees the values that stood at the edge
		#0;
	endtask : note
	task automatic tick(input int k);
		repeat (k) @(posedge aclk);
	endtask : tick
	task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
		end
		while (s_axi_bvalid !== 1'h1);
		s_axi_bready <= 1'h0;
		`CHK(r, s_axi_bresp);
	endtask : axw
	task automatic axr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'h0;
		end
		while (s_axi_rvalid !== 1'h1);
		s_axi_rready <= 1'h0;
		`CHK(d, s_axi_rdata);
		`CHK(r, s_axi_rresp);
	endtask : axr
	task automatic results();
		$display("Checks %0d, mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : results
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial
	begin
		tick(20);
		aresetn <= 1'h1;
		tick(1);
		`CHK(1'h1, clock_enable_n);
		`CHK(1'h0, power_ok_output_oe_n);
		`CHK(1'h0, power_ok_output_o);
		`CHK(1'h1, thermal_alert_n_oe_n);
		axr(4'h0, 32'h1, 2'h0);
		axr(4'hC, 32'h0, 2'h2);
		axw(4'hC, 32'h0, 2'h2);
		for (n = 0; n < 3; n++)
		begin
			voltage_code <= (n == 0) ? 7'h00 : (n == 1) ? 7'h7F : 7'($random(seed));
			tick(2);
			axr(4'h8, (voltage_code > 7'h78) ? 32'h0 : 32'hBB8 - 32'h19 * voltage_code, 2'h0);
		end
		$display("Test registers done");
		forced_emulation_enable <= 1'h1;
		deep_sleep_wake_n <= 1'h0;
		regulator_enable <= 1'h1;
		tick(40);
		`CHK(1'h0, converter_on);
		supply_ok <= 1'h1;
		n = 0;
		while (converter_on !== 1'h1)
		begin
			@(posedge aclk);
			n++;
		end
		`CHK(SD + 2, n);
		`CHK(1'h0, ramp_current_fast);
		win_req <= 1'h1;
		tick(80);
		`CHK(1'h1, clock_enable_n);
		`CHK(1'h1, soft_ref_level != 12'h000 && soft_ref_level < crss_pkg::BOOT_REF);
		pok_req <= 1'h1;
		tick(45);
		`CHK(1'h1, clock_enable_n);
		while (clock_enable_n !== 1'h0) @(posedge aclk);
		`CHK(1'h1, ramp_current_fast);
		`CHK(1'h0, diode_emulation);
		n = 0;
		while (power_ok_output_oe_n !== 1'h1)
		begin
			@(posedge aclk);
			n++;
		end
		`CHK(1'h1, n >= PG - 2 && n <= PG + 2);
		tick(2);
		`CHK(1'h1, diode_emulation);
		`CHK(1'h1, wide_hysteresis);
		`CHK(1'h1, deeper_sleep_mode);
		forced_emulation_enable <= 1'h0;
		deep_sleep_wake_n <= 1'h1;
		deeper_sleep_enable <= 1'h1;
		tick(3);
		`CHK(1'h0, ramp_current_fast);
		`CHK(1'h1, deeper_sleep_mode);
		`CHK(1'h0, wide_hysteresis);
		deeper_sleep_enable <= 1'h0;
		tick(3);
		`CHK(1'h1, ramp_current_fast);
		`CHK(1'h0, deeper_sleep_mode);
		$display("Test start-up and modes done");
		over_temperature <= 1'h1;
		tick(3);
		`CHK(1'h0, thermal_alert_n_oe_n);
		`CHK(1'h0, thermal_alert_n_o);
		axw(4'h0, 32'h0, 2'h0);
		tick(3);
		`CHK(1'h1, thermal_alert_n_oe_n);
		axw(4'h0, 32'h1, 2'h0);
		over_temperature <= 1'h0;
		pok_req <= 1'h0;
		tick(4);
		`CHK(1'h0, converter_on);
		`CHK(1'h0, power_ok_output_oe_n);
		`CHK(12'h000, soft_ref_level);
		pok_req <= 1'h1;
		tick(40);
		`CHK(1'h0, converter_on);
		axr(4'h4, 32'hD, 2'h0);
		regulator_enable <= 1'h0;
		tick(3);
		`CHK(1'h1, clock_enable_n);
		axr(4'h4, 32'h0, 2'h0);
		regulator_enable <= 1'h1;
		while (clock_enable_n !== 1'h0) @(posedge aclk);
		`CHK(1'h1, converter_on);
		$display("Test latch-off done");
		results();
	end
endmodule : test_crss_sequencer
`default_nettype wire
